//--- pcib_buf2.sv
// small ready/valid buffer between the pci read datapath and the internal master
`timescale 1ns/1ps
`default_nettype none
module pcib_buf2 #(
   parameter int W = 32,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // draining side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready,
   // fill level
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } pcib_buf_s;
   pcib_buf_s q, d;
   logic push, pop;

   // a word is only accepted while a slot is free, so nothing is overwritten
   always_comb begin
      d = q;
      push = in_valid && (q.cnt != CW'(DEPTH));
      pop = out_ready && (q.cnt != '0);
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp = (q.wp == PW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = (q.rp == PW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
      end
      d.cnt = q.cnt + CW'(push) - CW'(pop);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign in_ready = (q.cnt != CW'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rp];
   assign count = q.cnt;
endmodule
`default_nettype wire

//--- pcib_cfg.svh
// constants for the pci bus interface: commands, decode fields, timing counts
`ifndef PCIB_CFG_SVH
`define PCIB_CFG_SVH
`define PCIB_CMD_IORD 4'h2
`define PCIB_CMD_IOWR 4'h3
`define PCIB_CMD_MEMRD 4'h6
`define PCIB_CMD_MEMWR 4'h7
`define PCIB_CMD_CFGRD 4'hA
`define PCIB_CMD_CFGWR 4'hB
`define PCIB_BE_ALL 4'h0
`define PCIB_NUM_FUNC 3'h3
`define PCIB_CFG_TYPE0 2'h0
`define PCIB_MABORT_CLKS 3'h5
`define PCIB_ADDR_LSB_FUNC 8
`endif

//--- pcib_host_model.sv
// pci host model: initiator cycles, burst target, arbiter and pulled-up bus levels
`timescale 1ns/1ps
`default_nettype none
module pcib_host_model (
   // clock
   input wire logic sys_clk,
   // block drive values and enables
   input wire logic [31:0] ad_out,
   input wire logic ad_oe_n,
   input wire logic [3:0] cbe_out,
   input wire logic cbe_oe_n,
   input wire logic frame_n_out,
   input wire logic irdy_n_out,
   input wire logic mctl_oe_n,
   input wire logic trdy_n_out,
   input wire logic devsel_n_out,
   input wire logic stop_n_out,
   input wire logic tctl_oe_n,
   input wire logic req_n,
   input wire logic req_oe_n,
   // resolved levels seen by every agent
   output logic [31:0] ad_w,
   output logic [3:0] cbe_w,
   output logic frame_w,
   output logic irdy_w,
   output logic trdy_w,
   output logic devsel_w,
   output logic stop_w,
   output logic idsel,
   output logic gnt_n
);
   // drive state of the model; every oe flag is low while driving
   logic [31:0] h_ad = 32'h0, r_ad = 32'h0, maddr = 32'h0;
   logic [3:0] h_cbe = 4'hF, mcmd = 4'h0;
   logic h_oe_n = 1'h1, h_adoe_n = 1'h1, h_frame = 1'h1, h_irdy = 1'h1;
   logic r_oe_n = 1'h1, r_adoe = 1'h1, r_dev = 1'h1, r_trdy = 1'h1, act = 1'h0, pf = 1'h1;
   int k = 0, w = 0, lat = 1;
   // brst keeps frame low into the data phase; st holds stop as seen at the data edge
   logic brst = 1'h0, st = 1'h1;
   logic [31:0] wq[$];
   initial idsel = 1'h0;
   initial gnt_n = 1'h1;

   // released lines float to the pull-up level, never hold the last value
   assign ad_w = !ad_oe_n ? ad_out : !h_adoe_n ? h_ad : !r_adoe ? r_ad : 32'hFFFF_FFFF;
   assign cbe_w = !cbe_oe_n ? cbe_out : !h_oe_n ? h_cbe : 4'hF;
   assign frame_w = !mctl_oe_n ? frame_n_out : h_oe_n | h_frame;
   assign irdy_w = !mctl_oe_n ? irdy_n_out : h_oe_n | h_irdy;
   assign trdy_w = !tctl_oe_n ? trdy_n_out : r_oe_n | r_trdy;
   assign devsel_w = !tctl_oe_n ? devsel_n_out : r_oe_n | r_dev;
   assign stop_w = tctl_oe_n | stop_n_out;

   // one single-data-phase cycle; dv is the edge after the address that saw devsel
   task automatic cyc(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
         input logic [31:0] wd, output logic [31:0] rd, output int dv);
      int n;
      rd = 32'h0;
      dv = 0;
      n = 0;
      @(negedge sys_clk);
      h_oe_n = 1'h0;
      h_adoe_n = 1'h0;
      h_frame = 1'h0;
      h_ad = addr;
      h_cbe = cmd;
      idsel = sel;
      @(negedge sys_clk);
      h_frame = !brst;
      h_irdy = 1'h0;
      h_cbe = 4'h0;
      idsel = 1'h0;
      h_ad = wd;
      h_adoe_n = !cmd[0];
      // a read releases ad for turnaround; no devsel in time means master abort
      while (n < 12) begin
         @(posedge sys_clk);
         n++;
         if (!devsel_w && dv == 0) dv = n;
         if (!trdy_w && !irdy_w) begin
            rd = ad_w;
            st = stop_w;
            n = 99;
         end
      end
      @(negedge sys_clk);
      h_irdy = 1'h1;
      h_frame = 1'h1;
      h_adoe_n = 1'h1;
      @(negedge sys_clk);
      h_oe_n = 1'h1;
      repeat (3) @(negedge sys_clk);
   endtask

   // burst target for cycles the block starts, plus an arbiter that grants on request
   always begin
      @(posedge sys_clk);
      if (act && !irdy_w && !trdy_w) begin
         if (mcmd[0]) wq.push_back(ad_w);
         k++;
      end
      if (act && frame_w && irdy_w) act = 1'h0;
      if (w > 0) w--;
      if (!mctl_oe_n && !frame_w && pf) begin
         act = 1'h1;
         maddr = ad_w;
         mcmd = cbe_w;
         k = 0;
         w = lat;
      end
      pf = frame_w;
      @(negedge sys_clk);
      gnt_n = req_oe_n | req_n;
      r_ad = maddr + 32'(4 * k);
      // control lines go high for one cycle before they are let go
      if (act) begin
         r_oe_n = 1'h0;
         r_dev = (w != 0);
         r_trdy = (w != 0);
         r_adoe = mcmd[0] | (w != 0);
      end else if (!r_dev) begin
         r_dev = 1'h1;
         r_trdy = 1'h1;
         r_adoe = 1'h1;
      end else begin
         r_oe_n = 1'h1;
      end
   end
endmodule
`default_nettype wire

//--- pcib_pkg.sv
// types for the pci bus interface
package pcib_pkg;
   typedef enum logic [2:0] {T_IDLE, T_MED, T_DATA, T_ACK, T_XFER, T_TURN} pcib_tgt_e;
   typedef enum logic [1:0] {M_IDLE, M_REQ, M_DATA, M_END} pcib_mst_e;
endpackage

//--- pcib_top.sv
// pci target and burst master bridging the pci bus to internal slave and master buses
`include "pcib_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pcib_top #(
   parameter logic [31:0] IO_BASE = 32'h0000_0400,
   parameter logic [31:0] IO_MASK = 32'hFFFF_FF00,
   parameter logic [31:0] FDMA_BASE = 32'h0000_0500,
   parameter logic [31:0] FDMA_MASK = 32'hFFFF_FFF0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // pci address/data and command/byte enables
   input wire logic [31:0] ad_in,
   output logic [31:0] ad_out,
   output logic ad_oe_n,
   input wire logic [3:0] cbe_in,
   output logic [3:0] cbe_out,
   output logic cbe_oe_n,
   // pci initiator controls
   input wire logic frame_n_in,
   output logic frame_n_out,
   input wire logic irdy_n_in,
   output logic irdy_n_out,
   output logic mctl_oe_n,
   // pci target controls
   input wire logic trdy_n_in,
   output logic trdy_n_out,
   input wire logic devsel_n_in,
   output logic devsel_n_out,
   input wire logic stop_n_in,
   output logic stop_n_out,
   output logic tctl_oe_n,
   // pci arbitration and select
   input wire logic idsel_in,
   output logic req_n,
   output logic req_oe_n,
   input wire logic gnt_n,
   // internal slave bus
   output logic t_req,
   output logic t_write,
   output logic t_cfg,
   output logic [2:0] t_func,
   output logic [31:0] t_addr,
   output logic [3:0] t_be,
   output logic [31:0] t_wdata,
   input wire logic t_ack,
   input wire logic [31:0] t_rdata,
   // internal masters: index 0 dma, index 1 virtual registers
   input wire logic [1:0] m_req,
   input wire logic [1:0][31:0] m_addr,
   input wire logic [1:0] m_write,
   input wire logic [1:0][7:0] m_len,
   output logic [1:0] m_gnt,
   output logic [1:0] m_done,
   input wire logic [31:0] m_wdata,
   output logic m_wnext,
   output logic [31:0] m_rdata,
   output logic m_rvalid,
   input wire logic m_rready
);
   typedef struct packed {
      pcib_pkg::pcib_tgt_e ts;
      pcib_pkg::pcib_mst_e ms;
      logic fr_prev;
      logic devsel_n, trdy_n, stop_n, tctl_oe_n;
      logic [31:0] ad_out;
      logic ad_oe_n;
      logic [3:0] cbe_out;
      logic cbe_oe_n;
      logic frame_n, irdy_n, mctl_oe_n;
      logic req_n, req_oe_n;
      logic t_req, t_cfg, t_idsel, t_write;
      logic [2:0] t_func;
      logic [31:0] t_addr;
      logic [3:0] t_be;
      logic [31:0] t_wdata;
      logic [1:0] gnt;
      logic last;
      logic first;
      logic mwr;
      logic [7:0] left;
      logic [2:0] dcnt;
      logic [1:0] done;
      logic wnext;
   } pcib_top_s;

   // reset state: all enables high so every pin floats
   localparam pcib_top_s RST_VAL = '{ts: pcib_pkg::T_IDLE, ms: pcib_pkg::M_IDLE,
      fr_prev: 1'b1, devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1, tctl_oe_n: 1'b1,
      ad_out: 32'h0000_0000, ad_oe_n: 1'b1, cbe_out: 4'hF, cbe_oe_n: 1'b1,
      frame_n: 1'b1, irdy_n: 1'b1, mctl_oe_n: 1'b1, req_n: 1'b1, req_oe_n: 1'b1,
      t_req: 1'b0, t_cfg: 1'b0, t_idsel: 1'b0, t_write: 1'b0, t_func: 3'h0,
      t_addr: 32'h0000_0000, t_be: 4'h0, t_wdata: 32'h0000_0000, gnt: 2'h0,
      last: 1'b0, first: 1'b0, mwr: 1'b0, left: 8'h00, dcnt: 3'h0, done: 2'h0,
      wnext: 1'b0};

   pcib_top_s q, d;
   logic addr_ph, is_io, io_hit, fast_hit, cfg_hit, claim_fast, claim_med;
   logic sel, gi, start, done_ph, push, pop, fin;
   logic buf_in_ready;
   logic [1:0] buf_cnt, cnt_next;
   logic [7:0] left_d;

   // read data path: a stalled internal reader holds words here, pci irdy waits
   pcib_buf2 #(.W(32), .DEPTH(2)) u_rbuf (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(push),
      .in_data(ad_in),
      .in_ready(buf_in_ready),
      .out_valid(m_rvalid),
      .out_data(m_rdata),
      .out_ready(m_rready),
      .count(buf_cnt)
   );

   always_comb begin
      d = q;
      d.fr_prev = frame_n_in;
      d.done = 2'h0;
      d.wnext = 1'b0;
      // address phase decode; never while our own master owns the bus
      addr_ph = q.fr_prev && !frame_n_in && (q.ts == pcib_pkg::T_IDLE)
         && (q.ms == pcib_pkg::M_IDLE || q.ms == pcib_pkg::M_REQ);
      is_io = (cbe_in == `PCIB_CMD_IORD) || (cbe_in == `PCIB_CMD_IOWR);
      io_hit = is_io && ((ad_in & IO_MASK) == IO_BASE);
      fast_hit = is_io && ((ad_in & FDMA_MASK) == FDMA_BASE);
      cfg_hit = ((cbe_in == `PCIB_CMD_CFGRD) || (cbe_in == `PCIB_CMD_CFGWR)) && idsel_in
         && (ad_in[1:0] == `PCIB_CFG_TYPE0)
         && (ad_in[`PCIB_ADDR_LSB_FUNC +: 3] < `PCIB_NUM_FUNC);
      claim_fast = addr_ph && fast_hit;
      claim_med = addr_ph && !fast_hit && (io_hit || cfg_hit);
      // target machine
      case (q.ts)
         pcib_pkg::T_IDLE: begin
            if (claim_fast || claim_med) begin
               d.t_addr = ad_in;
               d.t_write = cbe_in[0];
               d.t_cfg = cfg_hit;
               d.t_idsel = idsel_in;
               d.t_func = cfg_hit ? ad_in[`PCIB_ADDR_LSB_FUNC +: 3] : 3'h0;
               d.tctl_oe_n = 1'b0;
               d.trdy_n = 1'b1;
               d.stop_n = 1'b1;
               d.devsel_n = !claim_fast;
               d.ts = claim_fast ? pcib_pkg::T_DATA : pcib_pkg::T_MED;
            end
         end
         pcib_pkg::T_MED: begin
            d.devsel_n = 1'b0;
            d.ts = pcib_pkg::T_DATA;
         end
         pcib_pkg::T_DATA: begin
            if (!irdy_n_in) begin
               d.t_req = 1'b1;
               d.t_be = cbe_in;
               d.t_wdata = ad_in;
               d.ts = pcib_pkg::T_ACK;
            end
         end
         pcib_pkg::T_ACK: begin
            if (t_ack) begin
               d.t_req = 1'b0;
               d.trdy_n = 1'b0;
               d.stop_n = frame_n_in; // one data phase only: disconnect a burst
               if (!q.t_write) begin
                  d.ad_out = t_rdata;
                  d.ad_oe_n = 1'b0;
               end
               d.ts = pcib_pkg::T_XFER;
            end
         end
         pcib_pkg::T_XFER: begin
            d.trdy_n = 1'b1;
            d.ad_oe_n = 1'b1;
            if (frame_n_in) begin
               d.devsel_n = 1'b1;
               d.stop_n = 1'b1;
               d.ts = pcib_pkg::T_TURN;
            end
         end
         pcib_pkg::T_TURN: begin
            d.tctl_oe_n = 1'b1;
            d.ts = pcib_pkg::T_IDLE;
         end
         default: d.ts = pcib_pkg::T_IDLE;
      endcase
      // arbitration: alternate when both ask
      sel = (m_req == 2'b11) ? !q.last : m_req[1];
      gi = q.gnt[1];
      start = (q.ms == pcib_pkg::M_REQ) && !gnt_n && frame_n_in && irdy_n_in;
      done_ph = (q.ms == pcib_pkg::M_DATA) && !q.first && !q.irdy_n && !trdy_n_in;
      push = done_ph && !q.mwr;
      pop = m_rvalid && m_rready;
      cnt_next = buf_cnt + 2'(push) - 2'(pop);
      left_d = done_ph ? q.left - 8'h01 : q.left;
      fin = 1'b0;
      // master machine
      case (q.ms)
         pcib_pkg::M_IDLE: begin
            if ((|m_req) && q.ts == pcib_pkg::T_IDLE && !addr_ph) begin
               d.gnt = sel ? 2'b10 : 2'b01;
               d.last = sel;
               d.req_n = 1'b0;
               d.req_oe_n = 1'b0;
               d.ms = pcib_pkg::M_REQ;
            end
         end
         pcib_pkg::M_REQ: begin
            if (start) begin
               d.ad_out = m_addr[gi];
               d.ad_oe_n = 1'b0;
               d.cbe_out = m_write[gi] ? `PCIB_CMD_MEMWR : `PCIB_CMD_MEMRD;
               d.cbe_oe_n = 1'b0;
               d.frame_n = 1'b0;
               d.irdy_n = 1'b1;
               d.mctl_oe_n = 1'b0;
               d.req_n = 1'b1;
               d.mwr = m_write[gi];
               d.left = (m_len[gi] == 8'h00) ? 8'h01 : m_len[gi];
               d.first = 1'b1;
               d.dcnt = 3'h0;
               d.ms = pcib_pkg::M_DATA;
            end
         end
         pcib_pkg::M_DATA: begin
            d.first = 1'b0;
            d.dcnt = devsel_n_in ? q.dcnt + 3'h1 : q.dcnt;
            // load the next word whenever one leaves, burst of dwords
            if (q.first || (done_ph && q.left > 8'h01)) begin
               d.cbe_out = `PCIB_BE_ALL;
               if (q.mwr) begin
                  d.ad_out = m_wdata;
                  d.wnext = 1'b1;
               end else begin
                  d.ad_oe_n = 1'b1; // read turnaround
               end
            end
            if (done_ph && (q.left == 8'h01 || !stop_n_in)) begin
               fin = 1'b1;
            end else if (!devsel_n_in && !stop_n_in && trdy_n_in && !q.first) begin
               fin = 1'b1; // retry or disconnect without data
            end else if (devsel_n_in && q.dcnt == `PCIB_MABORT_CLKS) begin
               fin = 1'b1; // master abort: nobody claimed
            end
            if (fin) begin
               d.frame_n = 1'b1;
               d.irdy_n = 1'b1;
               d.ms = pcib_pkg::M_END;
            end else begin
               // read wait states keep a free buffer slot for the next word
               d.irdy_n = !(q.mwr || cnt_next < 2'h2);
               d.frame_n = (!q.first && q.frame_n) || (!d.irdy_n && left_d == 8'h01);
            end
            d.left = left_d;
         end
         pcib_pkg::M_END: begin
            d.mctl_oe_n = 1'b1;
            d.ad_oe_n = 1'b1;
            d.cbe_oe_n = 1'b1;
            d.done = q.gnt;
            d.gnt = 2'h0;
            d.ms = pcib_pkg::M_IDLE;
         end
         default: d.ms = pcib_pkg::M_IDLE;
      endcase
   end

   // async reset floats every pin and idles both machines
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q <= RST_VAL;
      end else begin
         q <= d;
      end
   end

   assign ad_out = q.ad_out;
   assign ad_oe_n = q.ad_oe_n;
   assign cbe_out = q.cbe_out;
   assign cbe_oe_n = q.cbe_oe_n;
   assign frame_n_out = q.frame_n;
   assign irdy_n_out = q.irdy_n;
   assign mctl_oe_n = q.mctl_oe_n;
   assign trdy_n_out = q.trdy_n;
   assign devsel_n_out = q.devsel_n;
   assign stop_n_out = q.stop_n;
   assign tctl_oe_n = q.tctl_oe_n;
   assign req_n = q.req_n;
   assign req_oe_n = q.req_oe_n;
   assign t_req = q.t_req;
   assign t_write = q.t_write;
   assign t_cfg = q.t_cfg;
   assign t_func = q.t_func;
   assign t_addr = q.t_addr;
   assign t_be = q.t_be;
   assign t_wdata = q.t_wdata;
   assign m_gnt = q.gnt;
   assign m_done = q.done;
   assign m_wnext = q.wnext;

   // checks
   sequence s_med_slot;
      q.devsel_n ##1 !q.devsel_n;
   endsequence
   chk_fast_devsel: assert property (@(posedge sys_clk) disable iff (rst)
      claim_fast |=> !q.devsel_n && !q.tctl_oe_n) else $error("fast claim late");
   chk_med_devsel: assert property (@(posedge sys_clk) disable iff (rst)
      claim_med |=> s_med_slot) else $error("medium devsel timing wrong");
   chk_cfg_idsel: assert property (@(posedge sys_clk) disable iff (rst)
      ($rose(q.t_req) && q.t_cfg) |-> q.t_idsel) else $error("config claimed without idsel");
   chk_no_mem_claim: assert property (@(posedge sys_clk) disable iff (rst)
      (addr_ph && !is_io && !cfg_hit) |=> q.devsel_n && q.ts == pcib_pkg::T_IDLE)
      else $error("foreign cycle claimed");
   chk_rr_alt: assert property (@(posedge sys_clk) disable iff (rst)
      (q.ms == pcib_pkg::M_IDLE && m_req == 2'b11 && q.ts == pcib_pkg::T_IDLE && !addr_ph)
      |=> q.gnt[0] == $past(q.last)) else $error("round robin not alternating");
   chk_gnt_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (|q.gnt && q.ms != pcib_pkg::M_END) |=> $stable(q.gnt)) else $error("grant lost mid burst");
   chk_arb_one: assert property (@(posedge sys_clk) disable iff (rst)
      $onehot0(q.gnt)) else $error("two masters granted");
   chk_reset_float: assert property (@(posedge sys_clk) disable iff (1'b0)
      $past(rst) |-> q.ad_oe_n && q.mctl_oe_n && q.tctl_oe_n && q.req_oe_n && q.cbe_oe_n)
      else $error("pin driven out of reset");
   chk_addr_phase: assert property (@(posedge sys_clk) disable iff (rst)
      start |=> !q.frame_n && q.ad_out == $past(m_addr[gi]) && !q.ad_oe_n)
      else $error("master address not driven");
   chk_rbuf_room: assert property (@(posedge sys_clk) disable iff (rst)
      push |-> buf_in_ready) else $error("read word dropped");
endmodule
`default_nettype wire

//--- pcib_top_tb_top.sv
// testbench for the pci interface: decode timing, claims, config, bursts, reset
`include "pcib_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module pcib_top_tb_top;
   localparam logic [31:0] IOB = 32'h0000_0400;
   localparam logic [31:0] FDB = 32'h0000_0480;
   // clock, reset, counters and bench-driven inputs
   logic sys_clk = 1'h0, rst = 1'h1, t_ack = 1'h0, m_rready = 1'h0;
   int mismatches = 0, checks_done = 0, scnt = 0;
   logic [31:0] t_rdata = 32'h0, m_wdata = 32'hA000_0000, cap_wd = 32'h0;
   logic [1:0] m_req = 2'h0, m_write = 2'h0;
   logic [1:0][31:0] m_addr = '0;
   logic [1:0][7:0] m_len = '0;
   logic [8:0] cap = 9'h0;
   logic [31:0] rq[$];
   // block outputs and resolved bus levels
   logic [31:0] ad_out, t_addr, t_wdata, m_rdata, ad_w;
   logic [3:0] cbe_out, t_be, cbe_w;
   logic [2:0] t_func;
   logic [1:0] m_gnt, m_done;
   logic ad_oe_n, cbe_oe_n, frame_n_out, irdy_n_out, mctl_oe_n, trdy_n_out, devsel_n_out;
   logic stop_n_out, tctl_oe_n, req_n, req_oe_n, t_req, t_write, t_cfg, m_wnext, m_rvalid;
   logic frame_w, irdy_w, trdy_w, devsel_w, stop_w, idsel, gnt_n;

   pcib_top #(.FDMA_BASE(FDB)) pcib_top_i (.sys_clk(sys_clk), .rst(rst), .ad_in(ad_w),
      .ad_out(ad_out), .ad_oe_n(ad_oe_n), .cbe_in(cbe_w), .cbe_out(cbe_out),
      .cbe_oe_n(cbe_oe_n), .frame_n_in(frame_w), .frame_n_out(frame_n_out),
      .irdy_n_in(irdy_w), .irdy_n_out(irdy_n_out), .mctl_oe_n(mctl_oe_n),
      .trdy_n_in(trdy_w), .trdy_n_out(trdy_n_out), .devsel_n_in(devsel_w),
      .devsel_n_out(devsel_n_out), .stop_n_in(stop_w), .stop_n_out(stop_n_out),
      .tctl_oe_n(tctl_oe_n), .idsel_in(idsel), .req_n(req_n), .req_oe_n(req_oe_n),
      .gnt_n(gnt_n), .t_req(t_req), .t_write(t_write), .t_cfg(t_cfg), .t_func(t_func),
      .t_addr(t_addr), .t_be(t_be), .t_wdata(t_wdata), .t_ack(t_ack), .t_rdata(t_rdata),
      .m_req(m_req), .m_addr(m_addr), .m_write(m_write), .m_len(m_len), .m_gnt(m_gnt),
      .m_done(m_done), .m_wdata(m_wdata), .m_wnext(m_wnext), .m_rdata(m_rdata),
      .m_rvalid(m_rvalid), .m_rready(m_rready));

   pcib_host_model pcib_host_model_i (.sys_clk(sys_clk), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
      .cbe_out(cbe_out), .cbe_oe_n(cbe_oe_n), .frame_n_out(frame_n_out),
      .irdy_n_out(irdy_n_out), .mctl_oe_n(mctl_oe_n), .trdy_n_out(trdy_n_out),
      .devsel_n_out(devsel_n_out), .stop_n_out(stop_n_out), .tctl_oe_n(tctl_oe_n),
      .req_n(req_n), .req_oe_n(req_oe_n), .ad_w(ad_w), .cbe_w(cbe_w), .frame_w(frame_w),
      .irdy_w(irdy_w), .trdy_w(trdy_w), .devsel_w(devsel_w), .stop_w(stop_w),
      .idsel(idsel), .gnt_n(gnt_n));

   // clock at 40 MHz
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // internal slave answers in the third cycle; the write side steps on each take
   always @(negedge sys_clk) begin
      t_ack <= 1'h0;
      if (t_req && !t_ack) begin
         scnt <= scnt + 1;
         if (scnt == 2) begin
            t_ack <= 1'h1;
            t_rdata <= ~t_addr;
            cap <= {t_write, t_cfg, t_func, t_be};
            cap_wd <= t_wdata;
            scnt <= 0;
         end
      end
      if (m_wnext) m_wdata <= m_wdata + 32'h1;
   end

   // drained read words
   always @(posedge sys_clk) begin
      if (m_rvalid && m_rready) rq.push_back(m_rdata);
   end

   // reset is asynchronous: outputs float before any clock edge arrives
   task automatic t_reset();
      @(negedge sys_clk);
      rst = 1'h1;
      #1;
      `CHK({ad_oe_n, cbe_oe_n, mctl_oe_n, tctl_oe_n, req_oe_n}, 5'h1F)
      `CHK({t_req, m_gnt, m_done, m_wnext, m_rvalid}, 7'h00)
      repeat (3) @(negedge sys_clk);
      rst = 1'h0;
   endtask

   // io read in the medium range, io write in the fast range
   task automatic t_io();
      logic [31:0] rd;
      int dv;
      pcib_host_model_i.cyc(`PCIB_CMD_IORD, IOB + 32'h10, 1'h0, 32'h0, rd, dv);
      `CHK(dv, 2)
      `CHK(rd, ~(IOB + 32'h10))
      `CHK(cap, 9'h000)
      `CHK(pcib_host_model_i.st, 1'h1)
      // a host that keeps frame low is disconnected after its single data phase
      pcib_host_model_i.brst = 1'h1;
      pcib_host_model_i.cyc(`PCIB_CMD_IORD, IOB + 32'h20, 1'h0, 32'h0, rd, dv);
      pcib_host_model_i.brst = 1'h0;
      `CHK(pcib_host_model_i.st, 1'h0)
      `CHK(rd, ~(IOB + 32'h20))
      pcib_host_model_i.cyc(`PCIB_CMD_IOWR, FDB + 32'h4, 1'h0, 32'h1234_5678, rd, dv);
      `CHK(dv, 1)
      `CHK(cap_wd, 32'h1234_5678)
      `CHK(cap, 9'h100)
   endtask

   // every other command, an io miss, and config with and without select
   task automatic t_claims();
      logic [31:0] rd;
      int dv;
      for (int i = 0; i < 16; i++) begin
         if (i != 2 && i != 3) begin
            pcib_host_model_i.cyc(i[3:0], IOB, 1'h0, 32'h0, rd, dv);
            `CHK(dv, 0)
         end
      end
      pcib_host_model_i.cyc(`PCIB_CMD_IORD, IOB + 32'h100, 1'h0, 32'h0, rd, dv);
      `CHK(dv, 0)
      for (int f = 0; f < 4; f++) begin
         pcib_host_model_i.cyc(`PCIB_CMD_CFGRD, {21'h0, f[2:0], 8'h04}, 1'h1, 32'h0, rd, dv);
         `CHK(dv, (f < 3) ? 2 : 0)
         if (f < 3) `CHK(cap[7:4], {1'h1, f[2:0]})
      end
      pcib_host_model_i.cyc(`PCIB_CMD_CFGWR, 32'h0000_0004, 1'h1, 32'h55, rd, dv);
      `CHK(cap_wd, 32'h55)
      `CHK(cap[8:7], 2'h3)
   endtask

   // both internal masters at once; the read stalls on a full buffer
   task automatic t_master();
      logic [1:0] first;
      int dord;
      first = 2'h0;
      dord = 0;
      pcib_host_model_i.lat = 3;
      m_addr[0] = 32'hFFFF_FFF8;
      m_addr[1] = 32'h0000_1000;
      m_write = 2'h1;
      m_len[0] = 8'h02;
      m_len[1] = 8'h03;
      m_req = 2'h3;
      for (int n = 0; n < 400 && m_req !== 2'h0; n++) begin
         @(negedge sys_clk);
         if (first === 2'h0) first = m_gnt;
         if (m_done === 2'h2) dord = 1;
         if (m_done === 2'h1 && dord == 1) dord = 2;
         m_req = m_req & ~m_done;
         if (n == 40) begin
            `CHK(pcib_host_model_i.k < 3, 1'h1)
            `CHK(m_gnt, 2'h2)
            m_rready = 1'h1;
         end
      end
      repeat (4) @(negedge sys_clk);
      `CHK(first, 2'h2)
      `CHK(dord, 2)
      for (int i = 0; i < 3; i++) `CHK(rq[i], 32'h1000 + 32'(4 * i))
      for (int i = 0; i < 2; i++) `CHK(pcib_host_model_i.wq[i], 32'hA000_0000 + i)
      `CHK(pcib_host_model_i.maddr, 32'hFFFF_FFF8)
      `CHK(pcib_host_model_i.mcmd, `PCIB_CMD_MEMWR)
      // reset in the middle of a burst must float every pin without a clock
      m_req = 2'h1;
      for (int n = 0; n < 20 && mctl_oe_n !== 1'h0; n++) @(negedge sys_clk);
      m_req = 2'h0;
      `CHK(mctl_oe_n, 1'h0)
      t_reset();
   endtask

   // verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // main sequence; a second reset puts the round robin back to its start
   initial begin
      t_reset();
      t_io();
      t_claims();
      t_reset();
      t_master();
      conclude();
   end

   // watchdog: the run needs about 500 cycles
   initial begin
      #250000;
      mismatches++;
      conclude();
   end
endmodule
`default_nettype wire
